//--- core/fus_pkg.sv
/*
 Package for the frame update sync buffer: register map, field layouts,
 modes, record format and timing constants.
 Assumes a 10 MHz system clock and a 32-bit APB register bus.
*/
package fus_pkg;
   // clock rate in hertz
   localparam logic [23:0] CLK_HZ      = 24'h989680;
   localparam int          N_PATHS     = 6;
   localparam logic [11:0] FIFO_DEPTH  = 12'h800;
   localparam logic [11:0] PRIME_LEVEL = 12'h400;
   localparam logic [11:0] BUSY_LEVEL  = 12'h7fc;
   localparam logic [11:0] RATE_MIN    = 12'h001;
   localparam logic [11:0] RATE_MAX    = 12'h8fc;
   // attenuation in 0.1 dB steps, 50.0 dB top
   localparam logic [8:0]  ATTEN_MAX   = 9'h1f4;
   localparam logic [23:0] ATTEN_LIM   = 24'h0001f4;

   localparam logic [7:0] OFS_CTRL     = 8'h00;
   localparam logic [7:0] OFS_RATE     = 8'h04;
   localparam logic [7:0] OFS_PATHCFG  = 8'h08;
   localparam logic [7:0] OFS_STATUS   = 8'h0c;
   localparam logic [7:0] OFS_ERR      = 8'h10;
   localparam logic [7:0] OFS_IRQ_STAT = 8'h14;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h18;

   localparam int CTRL_START = 0;
   localparam int CTRL_DONE  = 1;
   localparam int EV_UNDERFLOW = 0;
   localparam int EV_BAD       = 1;
   localparam int EV_DRAINED   = 2;
   localparam int HDR_EOF      = 7;

   typedef enum logic [2:0] {ST_IDLE, ST_PRIME, ST_WAIT_TICK, ST_RELEASE, ST_DONE} fus_fsm_t;
   typedef enum logic [2:0] {FLD_TYPE, FLD_DMODE, FLD_DELAY, FLD_ATTEN, FLD_FPHASE} fus_field_t;
   typedef enum logic [1:0] {PT_OFF, PT_DOPPLER, PT_PHASE} fus_ptype_t;
   typedef enum logic [1:0] {DM_DEPTH, FINE_DELAY_MODE, DM_CLOCK} fus_dmode_t;

   typedef struct packed {
      logic [1:0]  ptype;
      logic [1:0]  dmode;
      logic [23:0] delay_ns;
      logic [8:0]  atten;
      logic [15:0] fphase;
   } fus_path_t;

   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [7:0]  paddr;
      logic [31:0] pwdata;
   } fus_apb_req_t;
endpackage

//--- core/fus_sync_buffer.sv
/*
 Frame update sync buffer: 2 kbyte byte FIFO fed from the host parallel
 port, primed then drained one frame per update tick into six path
 setting sets, with APB registers and an interrupt.
 Assumes strobe_n_i and data_i are asynchronous pins, data held stable
 around the strobe, and the host honouring busy_o.
*/
// Notes on behaviour
// RQ1: buffer holds 2048 setting bytes
// RQ2: release starts only after 1 kbyte primed; code also starts it once host done is set, with fewer bytes
// RQ3: one frame released per update tick
// RQ4: update tick programmable 1 Hz to 2.3 kHz
// RQ5: host keeps buffer near 1 kbyte; code raises busy_o only at 2044 bytes (BUSY_LEVEL)
// RQ6: host bytes accepted and forwarded to paths
// RQ7: empty buffer at tick records underflow
// RQ8: after host done, drain until empty
// RQ9: run start: declared paths on, zeroed
// RQ10: run start forces attenuation to 50 dB
// RQ11: off path halts its delay clock
// RQ12: depth, fine and clock delay modes
// RQ13: value is Doppler hertz or phase degrees
// RQ14: 0.1 dB and 1 ns resolution
// RQ15: attenuation above 50.0 dB is invalid
// RQ16: underflow sticky until read or restart
`timescale 1ns/10ps
module fus_sync_buffer
(
   input  wire  logic                                 clk_i,
   input  wire  logic                                 resetn_i,
   input  wire  fus_pkg::fus_apb_req_t                apb_i,
   output logic [31:0]                                prdata_o,
   output logic                                       pready_o,
   output logic                                       pslverr_o,
   input  wire  logic [7:0]                           data_i,
   input  wire  logic                                 strobe_n_i,
   output logic                                       busy_o,
   output fus_pkg::fus_path_t [fus_pkg::N_PATHS-1:0]  path_o,
   output logic [fus_pkg::N_PATHS-1:0]                delay_clk_en_o,
   output logic                                       irq_o
);
   import fus_pkg::*;

   typedef struct packed {
      logic [2047:0][7:0]     mem;
      logic [10:0]            wr_ptr;
      logic [10:0]            rd_ptr;
      logic [11:0]            count;
      logic                   strb_s1;
      logic                   strb_s2;
      logic                   strb_s3;
      logic [7:0]             data_s1;
      logic [7:0]             data_s2;
      fus_fsm_t               fsm;
      logic [23:0]            acc;
      logic                   tick;
      logic [1:0]             rec_idx;
      logic [7:0]             hdr;
      logic [15:0]            val;
      logic                   host_done;
      logic [11:0]            rate;
      logic [11:0]            pathcfg;
      fus_path_t [N_PATHS-1:0] paths;
      logic [N_PATHS-1:0]     clk_en;
      logic                   underflow;
      logic                   bad;
      logic [2:0]             irq_stat;
      logic [2:0]             irq_mask;
      logic                   irq;
      logic                   busy;
      logic [31:0]            prdata;
      logic                   pready;
      logic                   pslverr;
   } fus_state_t;

   fus_state_t s_q;
   fus_state_t s_d;
   logic       acc_wr;
   logic       start;
   logic       err_rd;

   always_comb
   begin
      logic [23:0] acc_sum;
      logic [23:0] v;
      logic [7:0]  rd_byte;
      logic        push;
      logic        pop;
      logic [2:0]  ev;
      logic [3:0]  pidx;
      acc_sum = '0;
      v       = '0;
      rd_byte = s_q.mem[s_q.rd_ptr];
      push    = 1'b0;
      pop     = 1'b0;
      ev      = '0;
      pidx    = s_q.hdr[3:0];
      s_d     = s_q;

      // apb slave: answer prepared in setup, effects at the access edge
      acc_wr = apb_i.psel && apb_i.penable && s_q.pready;
      start  = acc_wr && apb_i.pwrite && apb_i.paddr == OFS_CTRL && apb_i.pwdata[CTRL_START];
      err_rd = acc_wr && !apb_i.pwrite && apb_i.paddr == OFS_ERR;
      s_d.pready  = apb_i.psel && !apb_i.penable;
      s_d.pslverr = 1'b0;
      s_d.prdata  = '0;
      if (apb_i.psel && !apb_i.penable)
      begin
         unique case (apb_i.paddr)
            OFS_CTRL:     s_d.prdata = {30'h0, s_q.host_done, 1'b0};
            OFS_RATE:     s_d.prdata = {20'h0, s_q.rate};
            OFS_PATHCFG:  s_d.prdata = {20'h0, s_q.pathcfg};
            OFS_STATUS:   s_d.prdata = {16'h0, s_q.busy, s_q.fsm, s_q.count};
            OFS_ERR:      s_d.prdata = {30'h0, s_q.bad, s_q.underflow};
            OFS_IRQ_STAT: s_d.prdata = {29'h0, s_q.irq_stat};
            OFS_IRQ_MASK: s_d.prdata = {29'h0, s_q.irq_mask};
            default:      s_d.pslverr = 1'b1;
         endcase
      end
      if (acc_wr && apb_i.pwrite)
      begin
         unique case (apb_i.paddr)
            OFS_CTRL:     s_d.host_done = apb_i.pwdata[CTRL_DONE];
            OFS_RATE:                                                      // RQ4
            begin
               if (apb_i.pwdata[31:12] != '0 || apb_i.pwdata[11:0] > RATE_MAX)
                  s_d.rate = RATE_MAX;
               else if (apb_i.pwdata[11:0] < RATE_MIN)
                  s_d.rate = RATE_MIN;
               else
                  s_d.rate = apb_i.pwdata[11:0];
            end
            OFS_PATHCFG:  s_d.pathcfg = apb_i.pwdata[11:0];
            OFS_IRQ_STAT: s_d.irq_stat = s_q.irq_stat & ~apb_i.pwdata[2:0];
            OFS_IRQ_MASK: s_d.irq_mask = apb_i.pwdata[2:0];
            default:      s_d.pslverr = 1'b0;
         endcase
      end
      if (err_rd)
      begin
         s_d.underflow = s_q.underflow && !s_q.prdata[EV_UNDERFLOW];       // RQ16
         s_d.bad       = s_q.bad && !s_q.prdata[EV_BAD];
      end

      // host port pins: data two flops, strobe three; strobe held active high so reset equals idle
      s_d.strb_s1 = !strobe_n_i;
      s_d.strb_s2 = s_q.strb_s1;
      s_d.strb_s3 = s_q.strb_s2;
      s_d.data_s1 = data_i;
      s_d.data_s2 = s_q.data_s1;
      push = !s_q.strb_s2 && s_q.strb_s3 && s_q.count < FIFO_DEPTH;       // RQ1 RQ6

      // update tick by phase accumulation: no divider needed
      s_d.tick = 1'b0;
      if (s_q.fsm != ST_IDLE && s_q.fsm != ST_DONE)
      begin
         acc_sum = s_q.acc + {12'h0, s_q.rate};
         if (acc_sum >= CLK_HZ)
         begin
            s_d.acc  = acc_sum - CLK_HZ;
            s_d.tick = 1'b1;                                               // RQ4
         end
         else
            s_d.acc = acc_sum;
      end

      unique case (s_q.fsm)
         ST_IDLE, ST_DONE: s_d.fsm = s_q.fsm;
         ST_PRIME:
            if (s_q.count >= PRIME_LEVEL || s_q.host_done)
               s_d.fsm = ST_WAIT_TICK;                                     // RQ2
         ST_WAIT_TICK:
            if (s_q.tick)
            begin
               if (s_q.count != '0)
                  s_d.fsm = ST_RELEASE;                                    // RQ3 RQ8
               else if (s_q.host_done)
               begin
                  s_d.fsm = ST_DONE;                                       // RQ8
                  ev[EV_DRAINED] = 1'b1;
               end
               else
                  ev[EV_UNDERFLOW] = 1'b1;                                 // RQ7
            end
         ST_RELEASE:
         begin
            // a tick before the frame completes means real time was lost
            if (s_q.tick && !s_q.host_done)
               ev[EV_UNDERFLOW] = 1'b1;                                    // RQ7
            if (s_q.count != '0)
            begin
               pop = 1'b1;
               s_d.rec_idx = s_q.rec_idx + 2'h1;
               unique case (s_q.rec_idx)
                  2'h0: s_d.hdr = rd_byte;
                  2'h1: s_d.val[15:8] = rd_byte;
                  2'h2: s_d.val[7:0] = rd_byte;
                  2'h3:
                  begin
                     v = {s_q.val, rd_byte};
                     if (pidx >= 4'(N_PATHS))
                        ev[EV_BAD] = 1'b1;
                     else
                     begin
                        unique case (fus_field_t'(s_q.hdr[6:4]))
                           FLD_TYPE:
                              if (v > 24'(PT_PHASE))
                                 ev[EV_BAD] = 1'b1;
                              else
                                 s_d.paths[pidx[2:0]].ptype = v[1:0];
                           FLD_DMODE:                                      // RQ12
                              if (v > 24'(DM_CLOCK))
                                 ev[EV_BAD] = 1'b1;
                              else
                                 s_d.paths[pidx[2:0]].dmode = v[1:0];
                           FLD_DELAY: s_d.paths[pidx[2:0]].delay_ns = v;   // RQ14
                           FLD_ATTEN:                                      // RQ14
                              if (v > ATTEN_LIM)
                                 ev[EV_BAD] = 1'b1;                        // RQ15
                              else
                                 s_d.paths[pidx[2:0]].atten = v[8:0];
                           // hertz on Doppler paths, degrees on phase paths
                           FLD_FPHASE: s_d.paths[pidx[2:0]].fphase = v[15:0]; // RQ13
                           default: ev[EV_BAD] = 1'b1;
                        endcase
                     end
                     if (s_q.hdr[HDR_EOF])
                        s_d.fsm = ST_WAIT_TICK;                            // RQ3
                  end
                  default: s_d.rec_idx = '0;
               endcase
            end
         end
      endcase

      if (push)
      begin
         s_d.mem[s_q.wr_ptr] = s_q.data_s2;
         s_d.wr_ptr = s_q.wr_ptr + 11'h1;
      end
      if (pop)
         s_d.rd_ptr = s_q.rd_ptr + 11'h1;
      if (push && !pop)
         s_d.count = s_q.count + 12'h1;
      else if (pop && !push)
         s_d.count = s_q.count - 12'h1;

      // run start: flush and load run-start path defaults: types from pathcfg, attenuation at ATTEN_MAX
      if (start)
      begin
         s_d.fsm       = ST_PRIME;
         s_d.wr_ptr    = '0;
         s_d.rd_ptr    = '0;
         s_d.count     = '0;
         s_d.acc       = '0;
         s_d.tick      = 1'b0;
         s_d.rec_idx   = '0;
         s_d.host_done = 1'b0;
         s_d.underflow = 1'b0;                                             // RQ16
         s_d.bad       = 1'b0;
         for (int i = 0; i < N_PATHS; i++)
         begin
            s_d.paths[i].ptype    = (s_q.pathcfg[2*i +: 2] > 2'(PT_PHASE)) ?
                                    2'(PT_OFF) : s_q.pathcfg[2*i +: 2];   // RQ9
            s_d.paths[i].dmode    = 2'(DM_DEPTH);
            s_d.paths[i].delay_ns = '0;                                    // RQ9
            s_d.paths[i].fphase   = '0;                                    // RQ9
            s_d.paths[i].atten    = ATTEN_MAX;                             // RQ10
         end
      end

      // events win over any clear in the same cycle
      if (ev[EV_UNDERFLOW])
         s_d.underflow = 1'b1;                                             // RQ7 RQ16
      if (ev[EV_BAD])
         s_d.bad = 1'b1;
      s_d.irq_stat = s_d.irq_stat | ev;
      s_d.irq      = |(s_d.irq_stat & s_d.irq_mask);
      s_d.busy     = s_d.count >= BUSY_LEVEL;                              // RQ5
      for (int i = 0; i < N_PATHS; i++)
         s_d.clk_en[i] = s_d.paths[i].ptype != 2'(PT_OFF);                 // RQ11
   end

   always_ff @(posedge clk_i)
   begin
      if (!resetn_i)
      begin
         s_q     <= '0;
         s_q.fsm <= ST_IDLE;
      end
      else
         s_q <= s_d;
   end

   assign prdata_o       = s_q.prdata;
   assign pready_o       = s_q.pready;
   assign pslverr_o      = s_q.pslverr;
   assign busy_o         = s_q.busy;
   assign path_o         = s_q.paths;
   assign delay_clk_en_o = s_q.clk_en;
   assign irq_o          = s_q.irq;

   AST_CAPACITY: assert property (@(posedge clk_i) disable iff (!resetn_i) // RQ1
      s_q.count <= FIFO_DEPTH) else $error("buffer count beyond capacity");
   AST_NO_EARLY_RELEASE: assert property (@(posedge clk_i) disable iff (!resetn_i) // RQ2
      (s_q.fsm == ST_PRIME && !start) |=> s_q.rd_ptr == $past(s_q.rd_ptr))
      else $error("data released before priming");
   AST_RELEASE_ON_TICK: assert property (@(posedge clk_i) disable iff (!resetn_i) // RQ3
      (s_q.fsm == ST_WAIT_TICK && !s_q.tick && !start) |=> s_q.fsm == ST_WAIT_TICK)
      else $error("frame released without a tick");
   AST_TICK_SPACING: assert property (@(posedge clk_i) disable iff (!resetn_i) // RQ4
      s_q.tick |=> !s_q.tick [*8]) else $error("tick faster than top rate");
   AST_UNDERFLOW_SET: assert property (@(posedge clk_i) disable iff (!resetn_i) // RQ7
      (s_q.fsm == ST_WAIT_TICK && s_q.tick && s_q.count == '0 && !s_q.host_done
       && !start) |=> s_q.underflow && s_q.irq_stat[EV_UNDERFLOW])
      else $error("underflow not recorded");
   AST_DRAIN: assert property (@(posedge clk_i) disable iff (!resetn_i) // RQ8
      (s_q.fsm == ST_WAIT_TICK && s_q.tick && s_q.count != '0 && !start)
      |=> s_q.fsm == ST_RELEASE) else $error("frame not released while data left");
   AST_DEFAULTS: assert property (@(posedge clk_i) disable iff (!resetn_i) // RQ9
      start |=> (path_o[0].delay_ns == '0 && path_o[0].fphase == '0
                 && s_q.fsm == ST_PRIME)) else $error("run start defaults wrong");
   AST_ATTEN_MAX: assert property (@(posedge clk_i) disable iff (!resetn_i) // RQ10
      start |=> path_o[N_PATHS-1].atten == ATTEN_MAX) else $error("atten not at max");
   AST_OFF_CLOCK: assert property (@(posedge clk_i) disable iff (!resetn_i) // RQ11
      delay_clk_en_o[0] == (path_o[0].ptype != 2'(PT_OFF)))
      else $error("delay clock runs on off path");
   AST_ATTEN_RANGE: assert property (@(posedge clk_i) disable iff (!resetn_i) // RQ15
      path_o[1].atten <= ATTEN_MAX) else $error("attenuation out of range");
   AST_STICKY: assert property (@(posedge clk_i) disable iff (!resetn_i) // RQ16
      (s_q.underflow && !err_rd && !start) |=> s_q.underflow)
      else $error("underflow lost without read");

   COV_RELEASE: cover property (@(posedge clk_i) disable iff (!resetn_i)
      s_q.fsm == ST_RELEASE ##1 s_q.fsm == ST_WAIT_TICK);
   COV_UNDERFLOW: cover property (@(posedge clk_i) disable iff (!resetn_i)
      $rose(s_q.underflow));
   COV_DRAINED: cover property (@(posedge clk_i) disable iff (!resetn_i)
      $rose(s_q.irq_stat[EV_DRAINED]));
   COV_BUSY: cover property (@(posedge clk_i) disable iff (!resetn_i) $rose(busy_o));
endmodule // fus_sync_buffer

//--- tb/fus_host_model.sv
/*
 Host side of the parallel port: sends setting bytes one at a time with a
 strobe pulse, holding data past the strobe rise.
 Assumes the bench calls send_byte in order, never two calls at once.
*/
`timescale 1ns/10ps
module fus_host_model
(
   input  wire logic        clk_i,
   input  wire logic        busy_i,
   output logic [7:0]       data_o,
   output logic             strobe_n_o
);
   initial
   begin
      data_o = 8'h00;
      strobe_n_o = 1'b1;
   end

   // ign set sends even while busy, to overrun the buffer on purpose
   task automatic send_byte(input logic [7:0] b, input logic ign);
      int w;
      w = 0;
      while (busy_i !== 1'b0 && !ign && w < 20000)
      begin
         @(posedge clk_i);
         w++;
      end
      @(posedge clk_i);
      data_o <= b;
      strobe_n_o <= 1'b0;
      // shortest legal strobe spacing, so priming goes fast
      repeat (2) @(posedge clk_i);
      strobe_n_o <= 1'b1;
      repeat (4) @(posedge clk_i);
      // hold time over: lines no longer carry the byte
      data_o <= ~b;
   endtask
endmodule // fus_host_model

//--- tb/test_frame_update_sync_fifo.sv
/*
 Testbench for the frame update sync buffer: APB register access, host
 byte stream, frame release, underflow and interrupt.
 Assumes fus_pkg and the host model are compiled first.
*/
`timescale 1ns/10ps
module test_frame_update_sync_fifo;
   import fus_pkg::*;
   logic                    clk_i = 1'b0;
   logic                    resetn_i = 1'b0;
   fus_apb_req_t            apb_q = '0;
   logic [31:0]             prdata_o;
   logic                    pready_o;
   logic                    pslverr_o;
   logic                    busy_o;
   logic                    irq_o;
   logic                    strobe_n;
   logic [7:0]              data;
   fus_path_t [N_PATHS-1:0] path_o;
   logic [N_PATHS-1:0]      delay_clk_en_o;
   logic [31:0]             rd;
   logic                    err;
   int                      fail_count = 0;
   int                      n_tests = 0;
   int                      cyc = 0;
   int                      i;

   always #50 clk_i = ~clk_i;

   fus_sync_buffer u_fus_sync_buffer (.clk_i(clk_i), .resetn_i(resetn_i), .apb_i(apb_q),
      .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .data_i(data),
      .strobe_n_i(strobe_n), .busy_o(busy_o), .path_o(path_o),
      .delay_clk_en_o(delay_clk_en_o), .irq_o(irq_o));
   fus_host_model u_fus_host_model (.clk_i(clk_i), .busy_i(busy_o), .data_o(data),
      .strobe_n_o(strobe_n));

   task automatic results();
      $display("fail_count=%0d n_tests=%0d", fail_count, n_tests);
      if (fail_count == 0 && n_tests > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   always @(posedge clk_i)
   begin
      cyc++;
      if (cyc == 80000)
      begin
         fail_count++;
         $display("[ERR] %0t run did not finish", $time);
         results();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         fail_count++;
         $display("[ERR] %0t value %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chk_path(input fus_path_t got, input fus_path_t exp);
      n_tests++;
      if (got !== exp)
      begin
         fail_count++;
         $display("[ERR] %0t path %h expected %h", $time, got, exp);
      end
   endtask

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
      @(posedge clk_i);
      apb_q <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: wd};
      @(posedge clk_i);
      apb_q.penable <= 1'b1;
      do
         @(posedge clk_i);
      while (pready_o !== 1'b1);
      rd = prdata_o;
      err = pslverr_o;
      apb_q <= '0;
   endtask

   task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(rd & m, e);
   endtask

   task automatic chk_irq(input logic e);
      repeat (2) @(posedge clk_i);
      chk({31'h0, irq_o}, {31'h0, e});
   endtask

   task automatic rec(input logic eof, input fus_field_t f, input logic [3:0] p,
                      input logic [23:0] v);
      u_fus_host_model.send_byte({eof, f, p}, 1'b0);
      u_fus_host_model.send_byte(v[23:16], 1'b0);
      u_fus_host_model.send_byte(v[15:8], 1'b0);
      u_fus_host_model.send_byte(v[7:0], 1'b0);
   endtask

   task automatic wait_atten(input int p, input logic [8:0] v);
      int k;
      k = 0;
      while (path_o[p].atten !== v && k < 10000)
      begin
         @(posedge clk_i);
         k++;
      end
      chk({23'h0, path_o[p].atten}, {23'h0, v});
   endtask

   initial
   begin
      repeat (6) @(posedge clk_i);
      resetn_i <= 1'b1;
      rchk(OFS_STATUS, 32'hffffffff, 32'h0);
      apb(1'b0, 8'h1c, 32'h0);
      chk({err, rd[30:0]}, 32'h80000000);
      apb(1'b1, OFS_RATE, 32'h0);
      rchk(OFS_RATE, 32'hfff, 32'h1);
      apb(1'b1, OFS_RATE, 32'hfff);
      rchk(OFS_RATE, 32'hfff, {20'h0, RATE_MAX});
      apb(1'b1, OFS_PATHCFG, 32'hff9);
      apb(1'b1, OFS_CTRL, 32'h1);
      repeat (2) @(posedge clk_i);
      for (i = 0; i < N_PATHS; i++)
         chk_path(path_o[i], '{i == 0 ? PT_DOPPLER : i == 1 ? PT_PHASE : PT_OFF,
                  DM_DEPTH, 24'h0, ATTEN_MAX, 16'h0});
      chk({26'h0, delay_clk_en_o}, 32'h3);
      rec(1'b0, FLD_ATTEN, 4'h0, 24'h0001f5);
      rec(1'b0, FLD_DMODE, 4'h0, 24'h000001);
      rec(1'b0, FLD_DELAY, 4'h0, 24'h0004d2);
      rec(1'b0, FLD_FPHASE, 4'h1, 24'h000080);
      rec(1'b1, FLD_ATTEN, 4'h0, 24'h000032);
      rec(1'b0, FLD_FPHASE, 4'h0, 24'h00ffec);
      rec(1'b1, FLD_ATTEN, 4'h0, 24'h000000);
      rec(1'b1, FLD_TYPE, 4'h1, 24'h000000);
      repeat (5000) @(posedge clk_i);
      rchk(OFS_STATUS, 32'h7fff, 32'h1020);
      chk({23'h0, path_o[0].atten}, {23'h0, ATTEN_MAX});
      apb(1'b1, OFS_CTRL, 32'h2);
      wait_atten(0, 9'h032);
      chk_path(path_o[0], '{PT_DOPPLER, FINE_DELAY_MODE, 24'h0004d2, 9'h032, 16'h0});
      chk({16'h0, path_o[1].fphase}, 32'h80);
      repeat (100) @(posedge clk_i);
      chk({16'h0, path_o[0].fphase}, 32'h0);
      wait_atten(0, 9'h000);
      chk({16'h0, path_o[0].fphase}, 32'hffec);
      repeat (10000) @(posedge clk_i);
      chk({26'h0, delay_clk_en_o}, 32'h1);
      rchk(OFS_STATUS, 32'h7000, 32'h4000);
      rchk(OFS_IRQ_STAT, 32'h7, 32'h6);
      rchk(OFS_ERR, 32'h3, 32'h2);
      chk_irq(1'b0);
      apb(1'b1, OFS_IRQ_MASK, 32'h4);
      chk_irq(1'b1);
      apb(1'b1, OFS_IRQ_STAT, 32'h4);
      chk_irq(1'b0);
      // second run: rate 1 keeps ticks away while the buffer fills
      apb(1'b1, OFS_RATE, 32'h1);
      apb(1'b1, OFS_CTRL, 32'h1);
      rchk(OFS_ERR, 32'h3, 32'h0);
      for (i = 0; i < 2049; i++)
      begin
         if (i == 2044)
         begin
            chk({31'h0, busy_o}, 32'h1);
            rchk(OFS_STATUS, 32'h8fff, 32'h87fc);
         end
         u_fus_host_model.send_byte(i % 4 == 0 ? {i == 2044, FLD_ATTEN, 4'h1} :
                                    i % 4 == 3 ? 8'h64 : 8'h00, i >= 2044);
      end
      rchk(OFS_STATUS, 32'hfff, 32'h800);
      apb(1'b1, OFS_RATE, 32'h8fc);
      wait_atten(1, 9'h064);
      repeat (6000) @(posedge clk_i);
      rchk(OFS_IRQ_STAT, 32'h1, 32'h1);
      apb(1'b1, OFS_IRQ_MASK, 32'h1);
      chk_irq(1'b1);
      apb(1'b1, OFS_CTRL, 32'h2);
      rchk(OFS_ERR, 32'h1, 32'h1);
      rchk(OFS_ERR, 32'h1, 32'h0);
      apb(1'b1, OFS_IRQ_STAT, 32'h1);
      chk_irq(1'b0);
      results();
   end
endmodule // test_frame_update_sync_fifo
